/* File: dtfm_pkg.sv */
// constants and register map of the dual four-mode timer
// assumes one 25 MHz clock and an axi4-lite master reaching word registers
// Notes on behaviour
// - both timers count only upward; each is sixteen bits overall.
// - each timer is a readable, writable high byte and low byte.
// - a running timer steps every one or every two clocks, per halve select.
// - mode register holds timer one mode in 5:4, timer zero in 1:0.
// - both timers behave alike in modes zero to two; only mode three differs.
// - mode 0: high byte counts behind a divide-by-32 prescaler in low bits.
// - mode 1: low byte carries into high byte as one 16-bit counter.
// - mode 2: low byte counts and reloads from high byte on overflow.
// - mode 3: timer zero low byte uses timer zero run and flag.
// - mode 3: timer zero high byte uses timer one run and flag.
// - timer one in mode 3 stops and holds its count.
// - each run bit: zero stops counting, one enables counting.
// - each timer has an overflow flag that hardware sets.
// - rollover from all ones to all zeros sets the overflow flag, except timer one's while timer zero is in mode 3.
// - auto-reload leaves the high byte unchanged.
// - timer one in mode 3 acts as if its run bit were clear.
package dtfm_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] DTFM_IDX_CFG = 8'h88;
    localparam logic [7:0] DTFM_IDX_MODE = 8'h89;
    localparam logic [7:0] DTFM_IDX_TL0 = 8'h8a;
    localparam logic [7:0] DTFM_IDX_TL1 = 8'h8b;
    localparam logic [7:0] DTFM_IDX_TH0 = 8'h8c;
    localparam logic [7:0] DTFM_IDX_TH1 = 8'h8d;
    localparam logic [7:0] DTFM_IDX_CKDIV = 8'h8e;
    // config register bits
    localparam int DTFM_CFG_TF1 = 7;
    localparam int DTFM_CFG_TR1 = 6;
    localparam int DTFM_CFG_TF0 = 5;
    localparam int DTFM_CFG_TR0 = 4;
    // mode register field positions
    localparam int DTFM_MODE_T1_LO = 4;
    localparam int DTFM_MODE_T0_LO = 0;
    // clock divide control bits
    localparam int DTFM_CKDIV_T1 = 4;
    localparam int DTFM_CKDIV_T0 = 3;
    // mode encodings
    localparam logic [1:0] DTFM_M_PRESC = 2'h0;
    localparam logic [1:0] DTFM_M_CASC = 2'h1;
    localparam logic [1:0] DTFM_M_RELOAD = 2'h2;
    localparam logic [1:0] DTFM_M_SPLIT = 2'h3;
    localparam logic [4:0] DTFM_PRESC_MAX = 5'h1f;
    localparam logic [7:0] DTFM_BYTE_MAX = 8'hff;
    localparam logic [7:0] DTFM_RST_BYTE = 8'h00;
    localparam logic [1:0] DTFM_RST_MODE = 2'h0;
    localparam logic [1:0] DTFM_RESP_OKAY = 2'h0;
    localparam logic [1:0] DTFM_RESP_SLVERR = 2'h2;
endpackage

/* File: dtfm_tick_gen.sv */
// step enable for one counter: every clock, or every second clock
// assumes en and halve come from registers on the same clock
`timescale 1ns/1ps
module dtfm_tick_gen
    import dtfm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    input wire logic halve,
    output logic tick
);
    logic phase_ff;
    logic nxt_phase;

    always_comb begin
        nxt_phase = en ? ~phase_ff : 1'b0;
        tick = en & (~halve | phase_ff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end
endmodule

/* File: dtfm_axil_slave.sv */
// axi4-lite slave front end: one write and one read at a time
// assumes the register file decodes the index combinationally
`timescale 1ns/1ps
module dtfm_axil_slave
    import dtfm_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [7:0] wr_idx,
    output logic [7:0] wr_data,
    input wire logic wr_hit,
    output logic [7:0] rd_idx,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit
);
    logic aw_vld_ff, w_vld_ff, strb_ff, bvalid_ff, rvalid_ff, awhi_ff;
    logic nxt_aw_vld, nxt_w_vld, nxt_strb, nxt_bvalid, nxt_rvalid, nxt_awhi;
    logic [7:0] idx_ff, data_ff, nxt_idx, nxt_data;
    logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wr_fire, ar_ok;

    always_comb begin
        awready = ~aw_vld_ff & ~bvalid_ff;
        wready = ~w_vld_ff & ~bvalid_ff;
        arready = ~rvalid_ff;
        wr_idx = idx_ff;
        wr_data = data_ff;
        rd_idx = araddr[9:2];
        // upper address bits and byte offset must be zero to hit a register
        ar_ok = rd_hit && araddr[AW-1:10] == '0 && araddr[1:0] == 2'h0;
        wr_fire = aw_vld_ff & w_vld_ff & ~bvalid_ff;
        wr_en = wr_fire & strb_ff & wr_hit & ~awhi_ff;
        nxt_aw_vld = aw_vld_ff;
        nxt_w_vld = w_vld_ff;
        nxt_strb = strb_ff;
        nxt_awhi = awhi_ff;
        nxt_idx = idx_ff;
        nxt_data = data_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (awvalid && awready) begin
            nxt_aw_vld = 1'b1;
            nxt_idx = awaddr[9:2];
            nxt_awhi = awaddr[AW-1:10] != '0 || awaddr[1:0] != 2'h0;
        end
        if (wvalid && wready) begin
            nxt_w_vld = 1'b1;
            nxt_data = wdata[7:0];
            nxt_strb = wstrb[0];
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_aw_vld = 1'b0;
            nxt_w_vld = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = (wr_hit && !awhi_ff) ? DTFM_RESP_OKAY : DTFM_RESP_SLVERR;
        end
        if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = ar_ok ? {24'h000000, rd_data} : 32'h00000000;
            nxt_rresp = ar_ok ? DTFM_RESP_OKAY : DTFM_RESP_SLVERR;
        end
        bvalid = bvalid_ff;
        bresp = bresp_ff;
        rvalid = rvalid_ff;
        rresp = rresp_ff;
        rdata = rdata_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_vld_ff <= 1'b0;
            w_vld_ff <= 1'b0;
            strb_ff <= 1'b0;
            awhi_ff <= 1'b0;
            idx_ff <= 8'h00;
            data_ff <= 8'h00;
            bvalid_ff <= 1'b0;
            bresp_ff <= DTFM_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= DTFM_RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            aw_vld_ff <= nxt_aw_vld;
            w_vld_ff <= nxt_w_vld;
            strb_ff <= nxt_strb;
            awhi_ff <= nxt_awhi;
            idx_ff <= nxt_idx;
            data_ff <= nxt_data;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule

/* File: dtfm_timer.sv */
// two up-counting timers with four modes behind an axi4-lite register file
// assumes a single clock; the clock halve selects live in this block
`timescale 1ns/1ps
module dtfm_timer
    import dtfm_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag
);
    logic [7:0] tl_ff [2];
    logic [7:0] th_ff [2];
    logic [7:0] nxt_tl [2];
    logic [7:0] nxt_th [2];
    logic [1:0] m0_ff, m1_ff, nxt_m0, nxt_m1;
    logic tr0_ff, tr1_ff, tf0_ff, tf1_ff, t0h_ff, t1h_ff;
    logic nxt_tr0, nxt_tr1, nxt_tf0, nxt_tf1, nxt_t0h, nxt_t1h;
    logic wr_en, wr_hit, rd_hit;
    logic [7:0] wr_idx, wr_data, rd_idx, rd_data;
    logic [2:0] tick, tick_en, tick_halve;
    logic [16:0] r0, r1;
    logic ovf0, ovf1, ovfh;
    logic w_tl0, w_tl1, w_th0, w_th1, w_cfg, w_mode, w_ckdiv;

    dtfm_axil_slave #(.AW(AW)) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_hit(wr_hit),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // step enables: timer zero, timer one, timer zero high byte in split mode
    always_comb begin
        tick_en[0] = tr0_ff;
        // timer one in mode 3 sees no run
        tick_en[1] = tr1_ff & (m1_ff != DTFM_M_SPLIT);
        // split high byte runs on timer one run
        tick_en[2] = tr1_ff & (m0_ff == DTFM_M_SPLIT);
        tick_halve = {t0h_ff, t1h_ff, t0h_ff};
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_tick
            dtfm_tick_gen u_tick (
                .aclk(aclk),
                .aresetn(aresetn),
                .en(tick_en[gi]),
                .halve(tick_halve[gi]),
                .tick(tick[gi])
            );
        end
    endgenerate

    // one step of a counter in modes 0 to 2; split low byte takes the default
    // result is {overflow, high byte, low byte}
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] tl, input logic [7:0] th);
        logic [16:0] r;
        r = {1'b0, th, tl};
        case (m)
            // prescaler in low five bits; bits 7:5 just hold
            DTFM_M_PRESC: begin
                if (tl[4:0] == DTFM_PRESC_MAX) begin
                    r[4:0] = 5'h00;
                    r[15:8] = th + 8'h01;
                    r[16] = th == DTFM_BYTE_MAX;
                end else begin
                    r[4:0] = tl[4:0] + 5'h01;
                end
            end
            // low byte carries into high byte
            DTFM_M_CASC: begin
                r = {1'b0, th, tl} + 17'h00001;
            end
            // reload from high byte, high byte kept
            DTFM_M_RELOAD: begin
                if (tl == DTFM_BYTE_MAX) begin
                    r[7:0] = th;
                    r[16] = 1'b1;
                end else begin
                    r[7:0] = tl + 8'h01;
                end
            end
            default: begin
                r[7:0] = tl + 8'h01;
                r[16] = tl == DTFM_BYTE_MAX;
            end
        endcase
        return r;
    endfunction

    // register decode
    always_comb begin
        w_cfg = wr_en && wr_idx == DTFM_IDX_CFG;
        w_mode = wr_en && wr_idx == DTFM_IDX_MODE;
        w_tl0 = wr_en && wr_idx == DTFM_IDX_TL0;
        w_tl1 = wr_en && wr_idx == DTFM_IDX_TL1;
        w_th0 = wr_en && wr_idx == DTFM_IDX_TH0;
        w_th1 = wr_en && wr_idx == DTFM_IDX_TH1;
        w_ckdiv = wr_en && wr_idx == DTFM_IDX_CKDIV;
        wr_hit = wr_idx >= DTFM_IDX_CFG && wr_idx <= DTFM_IDX_CKDIV;
        rd_hit = rd_idx >= DTFM_IDX_CFG && rd_idx <= DTFM_IDX_CKDIV;
        // byte registers readable; reserved bits read zero
        case (rd_idx)
            DTFM_IDX_CFG: rd_data = {tf1_ff, tr1_ff, tf0_ff, tr0_ff, 4'h0};
            DTFM_IDX_MODE: rd_data = {2'h0, m1_ff, 2'h0, m0_ff};
            DTFM_IDX_TL0: rd_data = tl_ff[0];
            DTFM_IDX_TL1: rd_data = tl_ff[1];
            DTFM_IDX_TH0: rd_data = th_ff[0];
            DTFM_IDX_TH1: rd_data = th_ff[1];
            DTFM_IDX_CKDIV: rd_data = {3'h0, t1h_ff, t0h_ff, 3'h0};
            default: rd_data = 8'h00;
        endcase
    end

    // counters, flags and control
    always_comb begin
        nxt_tl = tl_ff;
        nxt_th = th_ff;
        // both timers share one step function
        r0 = step(m0_ff, tl_ff[0], th_ff[0]);
        r1 = step(m1_ff, tl_ff[1], th_ff[1]);
        // low byte of timer zero on its own run and flag
        ovf0 = tick[0] & r0[16] & ~w_tl0 & ~w_th0;
        // overflow of timer one is lost while timer zero owns its flag
        ovf1 = tick[1] & r1[16] & ~w_tl1 & ~w_th1 & (m0_ff != DTFM_M_SPLIT);
        ovfh = tick[2] & (th_ff[0] == DTFM_BYTE_MAX) & ~w_th0;
        if (tick[0]) begin
            nxt_tl[0] = r0[7:0];
            nxt_th[0] = r0[15:8];
        end
        if (tick[2]) begin
            nxt_th[0] = th_ff[0] + 8'h01;
        end
        if (tick[1]) begin
            nxt_tl[1] = r1[7:0];
            nxt_th[1] = r1[15:8];
        end
        // software write beats the hardware step
        if (w_tl0) begin
            nxt_tl[0] = wr_data;
        end
        if (w_th0) begin
            nxt_th[0] = wr_data;
        end
        if (w_tl1) begin
            nxt_tl[1] = wr_data;
        end
        if (w_th1) begin
            nxt_th[1] = wr_data;
        end
        nxt_tr0 = w_cfg ? wr_data[DTFM_CFG_TR0] : tr0_ff;
        nxt_tr1 = w_cfg ? wr_data[DTFM_CFG_TR1] : tr1_ff;
        // hardware set wins over a software clear
        nxt_tf0 = ovf0 | (w_cfg ? wr_data[DTFM_CFG_TF0] : tf0_ff);
        nxt_tf1 = ovf1 | ovfh | (w_cfg ? wr_data[DTFM_CFG_TF1] : tf1_ff);
        nxt_m0 = w_mode ? wr_data[DTFM_MODE_T0_LO +: 2] : m0_ff;
        nxt_m1 = w_mode ? wr_data[DTFM_MODE_T1_LO +: 2] : m1_ff;
        nxt_t0h = w_ckdiv ? wr_data[DTFM_CKDIV_T0] : t0h_ff;
        nxt_t1h = w_ckdiv ? wr_data[DTFM_CKDIV_T1] : t1h_ff;
        timer_zero_overflow_flag = tf0_ff;
        timer_one_overflow_flag = tf1_ff;
    end

    always_ff @(posedge aclk) begin
        // everything clears, timers stopped in mode 0
        if (!aresetn) begin
            tl_ff <= '{DTFM_RST_BYTE, DTFM_RST_BYTE};
            th_ff <= '{DTFM_RST_BYTE, DTFM_RST_BYTE};
            m0_ff <= DTFM_RST_MODE;
            m1_ff <= DTFM_RST_MODE;
            tr0_ff <= 1'b0;
            tr1_ff <= 1'b0;
            tf0_ff <= 1'b0;
            tf1_ff <= 1'b0;
            t0h_ff <= 1'b0;
            t1h_ff <= 1'b0;
        end else begin
            tl_ff <= nxt_tl;
            th_ff <= nxt_th;
            m0_ff <= nxt_m0;
            m1_ff <= nxt_m1;
            tr0_ff <= nxt_tr0;
            tr1_ff <= nxt_tr1;
            tf0_ff <= nxt_tf0;
            tf1_ff <= nxt_tf1;
            t0h_ff <= nxt_t0h;
            t1h_ff <= nxt_t1h;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_M1_CARRY: assert property (
        tick[0] && m0_ff == DTFM_M_CASC && tl_ff[0] == DTFM_BYTE_MAX && !w_tl0 && !w_th0 && !tick[2]
        |=> tl_ff[0] == 8'h00 && th_ff[0] == $past(th_ff[0]) + 8'h01)
        else $error("cascade carry missing");
    AST_M2_RELOAD: assert property (
        tick[0] && m0_ff == DTFM_M_RELOAD && tl_ff[0] == DTFM_BYTE_MAX && !w_tl0 && !w_th0
        |=> tl_ff[0] == $past(th_ff[0]) && $stable(th_ff[0]) && tf0_ff)
        else $error("reload wrong");
    AST_M0_PRESC: assert property (
        tick[0] && m0_ff == DTFM_M_PRESC && tl_ff[0][4:0] != DTFM_PRESC_MAX && !w_th0
        |=> $stable(th_ff[0]))
        else $error("prescaler let high byte move");
    AST_HALVE: assert property (
        tick[0] && t0h_ff && !w_ckdiv |=> !tick[0])
        else $error("halved timer stepped twice in a row");
    AST_STOPPED: assert property (
        !tr0_ff && !w_tl0 |=> $stable(tl_ff[0]))
        else $error("stopped timer moved");
    AST_T1_SPLIT_HOLD: assert property (
        m1_ff == DTFM_M_SPLIT && !w_tl1 && !w_th1 |=> $stable(tl_ff[1]) && $stable(th_ff[1]))
        else $error("timer one moved in mode 3");
    AST_SPLIT_HIGH_FLAG: assert property (
        m0_ff == DTFM_M_SPLIT && tr1_ff && th_ff[0] == DTFM_BYTE_MAX && !w_th0 && !t0h_ff
        |=> th_ff[0] == 8'h00 && tf1_ff)
        else $error("split high byte did not set timer one flag");
    AST_WR_PRIO: assert property (
        w_tl0 |=> tl_ff[0] == $past(wr_data))
        else $error("write lost to increment");
    AST_SET_WINS: assert property (
        ovf0 && w_cfg && !wr_data[DTFM_CFG_TF0] |=> tf0_ff)
        else $error("overflow lost under clear");
    AST_TICK_WITHIN: assert property (
        tr0_ff && !w_cfg ##1 tr0_ff |-> tick[0] || $past(tick[0]))
        else $error("running timer starved");

    CVR_RELOAD: cover property (tick[0] && m0_ff == DTFM_M_RELOAD && tl_ff[0] == DTFM_BYTE_MAX);
    CVR_SPLIT_HIGH: cover property (ovfh);
    CVR_M0_OVF: cover property (ovf0 && m0_ff == DTFM_M_PRESC);
    CVR_SET_CLEAR: cover property (ovf0 && w_cfg);
endmodule

/* File: tb_top.sv */
// self-checking bench for the dual four-mode timer over axi4-lite
// assumes the design answers within a few cycles and no shortening parameter
`timescale 1ns/1ps
module tb_top
    import dtfm_pkg::*;
;
    localparam int AW = 12;
    logic aclk, aresetn;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic timer_zero_overflow_flag, timer_one_overflow_flag;
    int bad_count = 0;
    int n_checks = 0;

    dtfm_timer #(.AW(AW)) dtfm_timer_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .timer_zero_overflow_flag(timer_zero_overflow_flag), .timer_one_overflow_flag(timer_one_overflow_flag));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // aw and w are offered together and each dropped on its own handshake
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] strb,
                             output logic [1:0] resp);
        logic got;
        got = 1'b0;
        resp = 2'h1;
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                got = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
        check_flag("write answered", 1'b1, got);
    endtask

    task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        logic got;
        got = 1'b0;
        d = 32'hffffffff;
        resp = 2'h1;
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                got = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
        check_flag("read answered", 1'b1, got);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_write(idx, d, 4'hf, r);
        check_resp("write resp", DTFM_RESP_OKAY, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        check_word(what, exp, d);
        check_resp(what, DTFM_RESP_OKAY, r);
    endtask

    task automatic rd_val(input logic [7:0] idx, output logic [7:0] v);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        v = d[7:0];
    endtask

    // bounded wait for one of the two overflow flags
    task automatic wait_flag(input logic one, input int limit, output logic seen);
        seen = 1'b0;
        for (int n = 0; n < limit && !seen; n++) begin
            @(posedge aclk);
            seen = one ? (timer_one_overflow_flag === 1'b1) : (timer_zero_overflow_flag === 1'b1);
        end
    endtask

    task automatic load(input logic [7:0] mode, input logic [7:0] tl0, input logic [7:0] th0,
                        input logic [7:0] tl1, input logic [7:0] th1);
        wr(DTFM_IDX_CFG, 8'h00);
        wr(DTFM_IDX_MODE, mode);
        wr(DTFM_IDX_TL0, tl0);
        wr(DTFM_IDX_TH0, th0);
        wr(DTFM_IDX_TL1, tl1);
        wr(DTFM_IDX_TH1, th1);
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd_chk("cfg reset", DTFM_IDX_CFG, 32'h0);
        rd_chk("mode reset", DTFM_IDX_MODE, 32'h0);
        rd_chk("tl0 reset", DTFM_IDX_TL0, 32'h0);
        rd_chk("tl1 reset", DTFM_IDX_TL1, 32'h0);
        rd_chk("th0 reset", DTFM_IDX_TH0, 32'h0);
        rd_chk("th1 reset", DTFM_IDX_TH1, 32'h0);
        axi_read(8'h20, d, r);
        check_resp("unmapped read", DTFM_RESP_SLVERR, r);
        check_word("unmapped data", 32'h0, d);
        $display("test reset done");
    endtask

    task automatic t_regs;
        logic [1:0] r;
        wr(DTFM_IDX_TH1, 8'ha5);
        rd_chk("th1 rw", DTFM_IDX_TH1, 32'ha5);
        axi_write(DTFM_IDX_TH1, 8'h3c, 4'h0, r);
        rd_chk("th1 no strobe", DTFM_IDX_TH1, 32'ha5);
        wr(DTFM_IDX_MODE, 8'hff);
        rd_chk("mode fields", DTFM_IDX_MODE, 32'h33);
        wr(DTFM_IDX_MODE, 8'h00);
        axi_write(8'h21, 8'h55, 4'hf, r);
        check_resp("unmapped write", DTFM_RESP_SLVERR, r);
        $display("test registers done");
    endtask

    // same run window at divide 1 and divide 2; bus latencies cancel out
    task automatic t_rate;
        logic [7:0] c[2];
        for (int h = 0; h < 2; h++) begin
            load(8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
            wr(DTFM_IDX_CKDIV, h ? 8'h08 : 8'h00);
            wr(DTFM_IDX_CFG, 8'h10);
            repeat (100) @(posedge aclk);
            wr(DTFM_IDX_CFG, 8'h00);
            rd_val(DTFM_IDX_TL0, c[h]);
        end
        wr(DTFM_IDX_CKDIV, 8'h00);
        check_flag("full rate span", 1'b1, c[0] >= 8'd100 && c[0] <= 8'd110);
        check_flag("half rate span", 1'b1, int'(c[0]) - 2 * int'(c[1]) inside {[-3:3]});
        $display("test rate done");
    endtask

    task automatic t_mode0;
        logic seen;
        load(8'h00, 8'h00, 8'hff, 8'h00, 8'h00);
        wr(DTFM_IDX_CFG, 8'h10);
        wait_flag(1'b0, 20, seen);
        check_flag("mode0 no early flag", 1'b0, seen);
        wait_flag(1'b0, 40, seen);
        check_flag("mode0 flag", 1'b1, seen);
        wr(DTFM_IDX_CFG, 8'h00);
        rd_chk("mode0 th0 wrap", DTFM_IDX_TH0, 32'h00);
        check_flag("flag cleared", 1'b0, timer_zero_overflow_flag);
        $display("test mode 0 done");
    endtask

    task automatic t_mode1;
        logic seen;
        load(8'h11, 8'hfc, 8'hff, 8'hfc, 8'hff);
        wr(DTFM_IDX_CFG, 8'h50);
        wait_flag(1'b0, 20, seen);
        check_flag("t0 cascade flag", 1'b1, seen);
        wait_flag(1'b1, 20, seen);
        check_flag("t1 cascade flag", 1'b1, seen);
        wr(DTFM_IDX_CFG, 8'h00);
        rd_chk("t0 cascade th0", DTFM_IDX_TH0, 32'h00);
        rd_chk("t1 cascade th1", DTFM_IDX_TH1, 32'h00);
        rd_chk("cfg cleared", DTFM_IDX_CFG, 32'h00);
        $display("test mode 1 done");
    endtask

    task automatic t_mode2;
        logic seen;
        logic [7:0] v;
        load(8'h02, 8'hfd, 8'ha0, 8'h00, 8'h00);
        wr(DTFM_IDX_CFG, 8'h10);
        wait_flag(1'b0, 20, seen);
        check_flag("reload flag", 1'b1, seen);
        wr(DTFM_IDX_CFG, 8'h00);
        rd_chk("reload keeps th0", DTFM_IDX_TH0, 32'ha0);
        rd_val(DTFM_IDX_TL0, v);
        check_flag("tl0 reloaded", 1'b1, v >= 8'ha0 && v < 8'hc0);
        $display("test mode 2 done");
    endtask

    task automatic t_split;
        logic seen;
        load(8'h03, 8'hfe, 8'hfe, 8'h00, 8'h00);
        wr(DTFM_IDX_CFG, 8'h40);
        wait_flag(1'b1, 20, seen);
        check_flag("split high sets t1 flag", 1'b1, seen);
        check_flag("t0 flag idle", 1'b0, timer_zero_overflow_flag);
        rd_chk("tl0 held while stopped", DTFM_IDX_TL0, 32'hfe);
        wr(DTFM_IDX_CFG, 8'h10);
        wait_flag(1'b0, 20, seen);
        check_flag("split low sets t0 flag", 1'b1, seen);
        check_flag("t1 flag cleared", 1'b0, timer_one_overflow_flag);
        $display("test mode 3 split done");
    endtask

    task automatic t_frozen;
        logic seen;
        load(8'h30, 8'h00, 8'h00, 8'hff, 8'hff);
        wr(DTFM_IDX_CFG, 8'h40);
        wait_flag(1'b1, 60, seen);
        check_flag("frozen t1 no flag", 1'b0, seen);
        wr(DTFM_IDX_CFG, 8'h00);
        rd_chk("frozen tl1", DTFM_IDX_TL1, 32'hff);
        rd_chk("frozen th1", DTFM_IDX_TH1, 32'hff);
        $display("test mode 3 timer one done");
    endtask

    // writes land on a counter stepping every clock
    task automatic t_prio;
        logic [7:0] v;
        load(8'h01, 8'h00, 8'h77, 8'h00, 8'h00);
        wr(DTFM_IDX_CFG, 8'h10);
        wr(DTFM_IDX_TH0, 8'h12);
        wr(DTFM_IDX_CFG, 8'h00);
        rd_chk("write beats step", DTFM_IDX_TH0, 32'h12);
        rd_val(DTFM_IDX_TL0, v);
        check_flag("counting upward", 1'b1, v > 8'h00 && v < 8'h40);
        $display("test write priority done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        bad_count++;
        $display("wrong value watchdog expected done seen hang");
        final_report();
    end

    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_regs();
        t_rate();
        t_mode0();
        t_mode1();
        t_mode2();
        t_split();
        t_frozen();
        t_prio();
        final_report();
    end
endmodule
